/* File: verilog/mbr_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants and types of the bus request block.
// ----------------------------------------------------------------------------
package mbr_pkg;

  // Request codes, high bit then low bit, both active low.
  localparam logic [1:0] CODE_HIGH = 2'h0;
  localparam logic [1:0] CODE_TERM = 2'h1;
  localparam logic [1:0] CODE_LOW = 2'h2;
  localparam logic [1:0] CODE_IDLE = 2'h3;

  // Refresh backlog at or above which refresh becomes urgent.
  localparam logic [7:0] REFRESH_URGENT = 8'h0c;

  // Width of the pending refresh count.
  localparam int REFRESH_W = 8;

  // Bus owner state.
  typedef enum logic [1:0] {
    MBR_IDLE,
    MBR_REQ,
    MBR_OWN,
    MBR_TERM
  } mbr_state_e;

  // Pending needs of the local side.
  typedef struct packed {
    logic vram_xfer;
    logic host_acc;
    logic cpu_acc;
    logic [7:0] refresh_pending;
  } mbr_need_s;

endpackage

/* File: verilog/mbr_prio.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Priority classifier: sorts pending needs into high and low classes.
// ----------------------------------------------------------------------------
module mbr_prio (
  input wire mbr_pkg::mbr_need_s need,
  output logic want_high,
  output logic want_low
);

  // Refresh is urgent once the backlog reaches the threshold.
  logic refresh_urgent;
  logic refresh_any;

  always_comb begin
    refresh_urgent = (need.refresh_pending >= mbr_pkg::REFRESH_URGENT);
    refresh_any = (need.refresh_pending != '0);
    // [R4] high class sources
    want_high = need.vram_xfer | need.host_acc | refresh_urgent;
    // [R5] low class sources
    want_low = need.cpu_acc | (refresh_any & ~refresh_urgent);
  end

endmodule

/* File: verilog/mbr_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Drive the bus only while grant low.
// [R2] Release the bus whenever grant high.
// [R3] Four request codes on two pins.
// [R4] Video, host, urgent refresh ask high.
// [R5] CPU and light refresh ask low.
// [R6] Arbiter grants high requests promptly.
// [R7] Show termination code while finishing access.
// [R8] High beats low; idle when nothing.

// ----------------------------------------------------------------------------
// Bus request and ownership logic of the local-memory bus.
// ----------------------------------------------------------------------------
module mbr_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic bus_grant_n,
  input wire mbr_pkg::mbr_need_s need,
  input wire logic access_last,
  output logic bus_request_code_hi,
  output logic bus_request_code_lo,
  output logic bus_drive,
  output logic access_start
);

  // Current state of the bus ownership sequence.
  mbr_pkg::mbr_state_e state;
  // Next state.
  mbr_pkg::mbr_state_e next_state;
  // Registered request code, driven onto the pins.
  logic [1:0] code;
  // Next value of the request code.
  logic [1:0] next_code;
  // Classified needs, as sorted by the priority classifier.
  logic want_high; // Some high class need is pending.
  logic want_low; // Some low class need is pending.
  logic want_any; // Either class is pending, so the bus is wanted.

  // ----------------------------------------------------------------------------
  // Classification of needs.
  // ----------------------------------------------------------------------------
  mbr_prio u_prio (
    .need(need),
    .want_high(want_high),
    .want_low(want_low)
  );

  assign want_any = want_high | want_low;

  // ----------------------------------------------------------------------------
  // Ownership sequencing.
  // ----------------------------------------------------------------------------

  // Next state picks up the grant; losing the grant always drops ownership.
  always_comb begin
    next_state = state;
    case (state)
      mbr_pkg::MBR_IDLE: begin
        if (want_any) begin
          next_state = mbr_pkg::MBR_REQ;
        end
      end
      mbr_pkg::MBR_REQ: begin
        // [R1] wait for grant
        if (!bus_grant_n) begin
          next_state = mbr_pkg::MBR_OWN;
        end else if (!want_any) begin
          next_state = mbr_pkg::MBR_IDLE;
        end
      end
      mbr_pkg::MBR_OWN: begin
        // [R2] grant lost releases
        if (bus_grant_n) begin
          next_state = want_any ? mbr_pkg::MBR_REQ : mbr_pkg::MBR_IDLE;
        end else if (access_last) begin
          next_state = mbr_pkg::MBR_TERM;
        end
      end
      mbr_pkg::MBR_TERM: begin
        // One cycle of termination, then compete again.
        next_state = want_any ? mbr_pkg::MBR_REQ : mbr_pkg::MBR_IDLE;
      end
      default: begin
        next_state = mbr_pkg::MBR_IDLE;
      end
    endcase
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= mbr_pkg::MBR_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------------
  // Request code.
  // ----------------------------------------------------------------------------

  // Code follows the next state so pins and state change together.
  always_comb begin
    // [R8] high over low
    if (next_state == mbr_pkg::MBR_TERM) begin
      // [R7] termination code shown
      next_code = mbr_pkg::CODE_TERM;
    end else if (want_high) begin
      // [R3] high priority code
      next_code = mbr_pkg::CODE_HIGH;
    end else if (want_low) begin
      next_code = mbr_pkg::CODE_LOW;
    end else begin
      next_code = mbr_pkg::CODE_IDLE;
    end
  end

  // Code register; idle after reset so no master sees a false request.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      code <= mbr_pkg::CODE_IDLE;
    end else if (clk_en) begin
      code <= next_code;
    end
  end

  assign bus_request_code_hi = code[1];
  assign bus_request_code_lo = code[0];

  // ----------------------------------------------------------------------------
  // Bus drive.
  // ----------------------------------------------------------------------------

  // Drive is gated by the live grant, so release is immediate when it rises.
  always_comb begin
    // [R2] drop drive now
    bus_drive = (state == mbr_pkg::MBR_OWN) && !bus_grant_n;
  end

  // Start pulse marks the first owned cycle.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      access_start <= 1'b0;
    end else if (clk_en) begin
      // [R1] start under grant
      access_start <= (state == mbr_pkg::MBR_REQ) && !bus_grant_n;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------------

  // Grant then last access leads to termination code.
  sequence s_finish;
    clk_en && state == mbr_pkg::MBR_OWN && !bus_grant_n && access_last;
  endsequence

  // Ownership newly taken: owned now, not owned in the cycle before.
  sequence s_take;
    state == mbr_pkg::MBR_OWN && $past(state) != mbr_pkg::MBR_OWN;
  endsequence

  // Grant seen high while owning, with the clock enabled.
  sequence s_lose;
    clk_en && state == mbr_pkg::MBR_OWN && bus_grant_n;
  endsequence

  // Refresh backlog at or above the urgent level, with no termination due.
  sequence s_refresh_urgent;
    clk_en && need.refresh_pending >= mbr_pkg::REFRESH_URGENT &&
      next_state != mbr_pkg::MBR_TERM;
  endsequence

  // Light refresh with no video or host need beside it.
  // The threshold is restated here rather than taken from the classifier,
  // so a fault in the classifier shows up as a failure.
  sequence s_refresh_light;
    clk_en && !need.vram_xfer && !need.host_acc && need.refresh_pending != 8'h00 &&
      need.refresh_pending < mbr_pkg::REFRESH_URGENT &&
      next_state != mbr_pkg::MBR_TERM;
  endsequence

  // Ownership is only ever taken from a request under a low grant.
  AST_DRIVE_GRANT: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
    s_take |-> $past(!bus_grant_n) && $past(state) == mbr_pkg::MBR_REQ)
    else $error("bus taken without grant");

  // A high grant while owning gives the bus up at the next enabled edge.
  AST_RELEASE: assert property (@(posedge core_clk) disable iff (!nrst) // [R2]
    s_lose |=> state != mbr_pkg::MBR_OWN)
    else $error("bus held while grant high");

  AST_TERM: assert property (@(posedge core_clk) disable iff (!nrst) // [R7]
    s_finish |=> ({bus_request_code_hi, bus_request_code_lo} == mbr_pkg::CODE_TERM))
    else $error("termination code missing");

  AST_HIGH: assert property (@(posedge core_clk) disable iff (!nrst) // [R4]
    (clk_en && need.host_acc && next_state != mbr_pkg::MBR_TERM)
      |=> (code == mbr_pkg::CODE_HIGH))
    else $error("host access not high priority");

  AST_LOW: assert property (@(posedge core_clk) disable iff (!nrst) // [R5]
    (clk_en && need.cpu_acc && !want_high && next_state != mbr_pkg::MBR_TERM)
      |=> (code == mbr_pkg::CODE_LOW))
    else $error("cpu access not low priority");

  AST_IDLE: assert property (@(posedge core_clk) disable iff (!nrst) // [R8]
    (clk_en && !want_any && next_state != mbr_pkg::MBR_TERM)
      |=> (code == mbr_pkg::CODE_IDLE))
    else $error("idle code missing");

  // The termination code only appears straight out of an owned access.
  // A frozen clock enable may hold it longer, so only its entry is checked.
  AST_CODE_LEGAL: assert property (@(posedge core_clk) disable iff (!nrst) // [R3]
    (code == mbr_pkg::CODE_TERM && $past(code) != mbr_pkg::CODE_TERM)
      |-> $past(state) == mbr_pkg::MBR_OWN)
    else $error("termination code outside an access");

  // A start pulse that was freshly made must have seen the grant low.
  AST_START: assert property (@(posedge core_clk) disable iff (!nrst) // [R1]
    (access_start && $past(clk_en)) |-> $past(!bus_grant_n))
    else $error("start without grant");

  // Twelve or more pending refreshes ask with the high code.
  AST_REFRESH_HIGH: assert property (@(posedge core_clk) disable iff (!nrst) // [R4]
    s_refresh_urgent |=> (code == mbr_pkg::CODE_HIGH))
    else $error("urgent refresh not high priority");

  // One to eleven pending refreshes alone ask with the low code.
  AST_REFRESH_LOW: assert property (@(posedge core_clk) disable iff (!nrst) // [R5]
    s_refresh_light |=> (code == mbr_pkg::CODE_LOW))
    else $error("light refresh not low priority");

endmodule

/* File: tb/mbr_arb_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Arbiter model standing at the far side of the shared bus.
// ----------------------------------------------------------------------------
module mbr_arb_model (
  input wire logic core_clk,
  input wire logic code_hi,
  input wire logic code_lo,
  input wire logic revoke,
  output logic bus_grant_n
);
  // Starts with the bus withheld, so nothing is owned before a request.
  initial bus_grant_n = 1'b1;

  // Grants on the edge after any request; revoke stands in for a busy
  // or slow arbiter that holds the grant back.
  // prompt grant
  always @(posedge core_clk) begin
    if (revoke || {code_hi, code_lo} == mbr_pkg::CODE_IDLE ||
        {code_hi, code_lo} == mbr_pkg::CODE_TERM) begin
      bus_grant_n <= 1'b1;
    end else begin
      bus_grant_n <= 1'b0;
    end
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Testbench of the bus request block.
// ----------------------------------------------------------------------------
module tb;
  logic core_clk, nrst, clk_en, bus_grant_n, access_last, revoke;
  logic code_hi, code_lo, bus_drive, access_start;
  mbr_pkg::mbr_need_s need;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  mbr_top uut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .bus_grant_n(bus_grant_n), .need(need), .access_last(access_last),
    .bus_request_code_hi(code_hi), .bus_request_code_lo(code_lo),
    .bus_drive(bus_drive), .access_start(access_start));
  mbr_arb_model arb (.core_clk(core_clk), .code_hi(code_hi), .code_lo(code_lo),
    .revoke(revoke), .bus_grant_n(bus_grant_n));

  // The 50 ns clock.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // A hang is cut short well past the fewer than one hundred cycles needed.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_of_test();
    end
  end

  task chk(string name, logic [1:0] seen, logic [1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Waits, bounded, for the first owned cycle.
  task wait_start;
    int i;
    i = 0;
    while (access_start !== 1'b1 && i < 20) begin
      @(negedge core_clk);
      i++;
    end
  endtask

  // One full transfer: request, optional slow grant, access, termination.
  task serve(mbr_pkg::mbr_need_s n, logic [1:0] code, int slow, string name);
    need = n;
    revoke = (slow > 0);
    @(negedge core_clk);
    chk("request code", {code_hi, code_lo}, code);
    repeat (slow) @(negedge core_clk);
    chk("held code", {code_hi, code_lo}, code);
    revoke = 1'b0;
    wait_start();
    chk("drive when granted", {access_start, bus_drive}, 2'h3);
    access_last = 1'b1;
    need = '0;
    @(negedge core_clk);
    access_last = 1'b0;
    chk("term code", {code_hi, code_lo}, mbr_pkg::CODE_TERM);
    chk("drive in term", {1'b0, bus_drive}, 2'h0);
    @(negedge core_clk);
    chk("idle code", {code_hi, code_lo}, mbr_pkg::CODE_IDLE);
    $display("test %s done", name);
  endtask

  // Grant taken away in mid-access must stop the drive at once.
  task drop_grant;
    need = '{1'b0, 1'b1, 1'b0, 8'h00};
    wait_start();
    revoke = 1'b1;
    @(negedge core_clk);
    chk("drive after revoke", {1'b0, bus_drive}, 2'h0);
    need = '0;
    revoke = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("idle after drop", {code_hi, code_lo}, mbr_pkg::CODE_IDLE);
    $display("test drop_grant done");
  endtask

  // A low clock enable freezes both the request and an owned access.
  task test_freeze;
    clk_en = 1'b0;
    need = '{1'b0, 1'b0, 1'b1, 8'h00};
    repeat (2) @(negedge core_clk);
    chk("frozen code", {code_hi, code_lo}, mbr_pkg::CODE_IDLE);
    clk_en = 1'b1;
    @(negedge core_clk);
    chk("thawed code", {code_hi, code_lo}, mbr_pkg::CODE_LOW);
    wait_start();
    clk_en = 1'b0;
    access_last = 1'b1;
    need = '0;
    @(negedge core_clk);
    chk("frozen owner", {access_start, bus_drive}, 2'h3);
    chk("frozen access code", {code_hi, code_lo}, mbr_pkg::CODE_LOW);
    clk_en = 1'b1;
    @(negedge core_clk);
    access_last = 1'b0;
    chk("term after thaw", {code_hi, code_lo}, mbr_pkg::CODE_TERM);
    @(negedge core_clk);
    chk("idle after thaw", {code_hi, code_lo}, mbr_pkg::CODE_IDLE);
    $display("test freeze done");
  endtask

  // Host access asks high and is served at once.
  task test_host;
    serve('{1'b0, 1'b1, 1'b0, 8'h00}, mbr_pkg::CODE_HIGH, 0, "host");
  endtask

  // Video transfer asks high and holds through a slow grant.
  task test_vram;
    serve('{1'b1, 1'b0, 1'b0, 8'h00}, mbr_pkg::CODE_HIGH, 3, "vram");
  endtask

  // Own CPU access asks low.
  task test_cpu;
    serve('{1'b0, 1'b0, 1'b1, 8'h00}, mbr_pkg::CODE_LOW, 2, "cpu");
  endtask

  // Refresh backlog right at the urgent level asks high.
  task test_refresh12;
    serve('{1'b0, 1'b0, 1'b0, 8'h0c}, mbr_pkg::CODE_HIGH, 0, "refresh12");
  endtask

  // Refresh backlog one below the urgent level asks low.
  task test_refresh11;
    serve('{1'b0, 1'b0, 1'b0, 8'h0b}, mbr_pkg::CODE_LOW, 0, "refresh11");
  endtask

  // High and low needs together show the high code.
  task test_mixed;
    serve('{1'b0, 1'b1, 1'b1, 8'h01}, mbr_pkg::CODE_HIGH, 1, "mixed");
  endtask

  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    access_last = 1'b0;
    revoke = 1'b0;
    need = '0;
    repeat (2) @(negedge core_clk);
    chk("reset code", {code_hi, code_lo}, mbr_pkg::CODE_IDLE);
    nrst = 1'b1;
    test_host();
    test_vram();
    test_cpu();
    test_refresh12();
    test_refresh11();
    test_mixed();
    drop_grant();
    test_freeze();
    end_of_test();
  end
endmodule
